//--- lbd_device.sv
// driver-side control: clock select, sync watch, enable and trim
`timescale 1ns/100ps
`default_nettype none
`include "lbd_defs.svh"
module lbd_device
#(
  parameter int unsigned LOWPWR_CYC     = `LBD_LOWPWR_CYC,
  parameter int unsigned FIRST_HIGH_CYC = `LBD_FIRST_HIGH_CYC,
  parameter int unsigned DETECT_TICKS   = `LBD_DETECT_TICKS
)
(
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  // link to the controller
  lbd_link_if.dev                link,
  // supply and resistor setting
  input  wire logic              vin_ok_i,
  input  wire logic [8:0]        osc_period_i,
  // converter controls
  output logic                   sw_clk_o,
  output logic                   boost_en_o,
  output logic                   sink_en_o,
  output logic                   comp_float_o,
  output logic                   disc_sw_on_o,
  output logic [7:0]             trim_level_o,
  // status
  output logic                   ext_sync_o,
  output logic                   shutdown_o,
  output logic                   low_power_o,
  output lbd_pkg::lbd_state_t    state_o
);
  import lbd_pkg::*;

  localparam logic [8:0]  PER_MIN = 9'(`LBD_PER_MIN);
  localparam logic [8:0]  PER_MAX = 9'(`LBD_PER_MAX);
  localparam logic [10:0] LOSS    = 11'(`LBD_LOSS_CYC);
  localparam logic [10:0] GAP     = 11'(`LBD_GAP_CYC);
  localparam logic [10:0] REL     = 11'(`LBD_REL_CYC);
  localparam logic [11:0] DET_N   = 12'(DETECT_TICKS);
  localparam logic [23:0] LP_N    = 24'(LOWPWR_CYC);
  localparam logic [15:0] FH_N    = 16'(FIRST_HIGH_CYC);
  localparam int          WB      = `LBD_TRIM_WIN_BITS;
  localparam int          SB      = `LBD_SLEW_BITS;

  logic [3:0]  pins_s;
  logic        en_s;
  logic        sync_s;
  logic        freq_set_pin_s;
  logic        trim_s;
  logic        sync_d;
  logic [8:0]  osc_cnt;
  logic        use_ext;
  logic        present;
  logic [10:0] gap_cnt;
  logic [10:0] sd_cnt;
  logic [11:0] det_cnt;
  logic        cur_d;
  logic [23:0] lo_cnt;
  logic [15:0] hi_cnt;
  logic [WB-1:0] win_cnt;
  logic [WB-1:0] duty_cnt;
  logic [7:0]  target;
  logic [SB-1:0] slew_cnt;
  lbd_state_t  state;
  lbd_state_t  next_state;

  // pins come from another domain
  lbd_sync2 #(.W(4)) u_sync
  (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .d_i       ({link.current_trim_pwm_input, link.freq_set_pin,
                 link.sync_clk, link.en_dim}),
    .q_o       (pins_s)
  );
  assign en_s   = pins_s[0];
  assign sync_s = pins_s[1];
  assign freq_set_pin_s = pins_s[2];
  assign trim_s = pins_s[3];

  // resistor period, clamped to the allowed band
  wire [8:0] osc_lim  = (osc_period_i < PER_MIN) ? PER_MIN :
                        (osc_period_i > PER_MAX) ? PER_MAX :
                        osc_period_i;
  wire       osc_wrap = (osc_cnt >= osc_lim - 9'd1);
  wire       osc_lvl  = (osc_cnt < {1'b0, osc_lim[8:1]});

  // sync edge timing and presence
  wire sync_rise = sync_s & ~sync_d;
  wire gap_lost  = (gap_cnt >= LOSS);
  wire gap_max   = (gap_cnt >= GAP);

  // glitch-free source: swap only while both sources sit low, or back to internal when a gap times out
  wire cur_lvl  = use_ext ? sync_s : osc_lvl;
  wire cur_rise = cur_lvl & ~cur_d;
  wire swap_ok  = ~sync_s & ~osc_lvl;

  // frequency pin low with no sync means a short
  wire freq_set_pin_short = ~freq_set_pin_s & ~present;
  wire start_ok   = vin_ok_i & (hi_cnt >= FH_N)
                  & (freq_set_pin_s | present);

  wire st_run  = (state == LBD_RUN);
  wire st_det  = (state == LBD_DET);
  wire st_gap  = (state == LBD_GAP);
  wire det_end = (det_cnt >= DET_N);

  // next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      LBD_OFF:
        if (start_ok)
          next_state = LBD_DET;
      LBD_DET:
        if (!vin_ok_i)
          next_state = LBD_OFF;
        else if (freq_set_pin_short)
          next_state = LBD_SHUT;
        else if (det_end)
          next_state = LBD_RUN;
      LBD_RUN:
        if (!vin_ok_i)
          next_state = LBD_OFF;
        else if (freq_set_pin_short)
          next_state = LBD_SHUT;
        else if (use_ext && gap_lost)
          next_state = LBD_GAP;
        else if (lo_cnt >= LP_N)
          next_state = LBD_LOWP;
      LBD_GAP:
        if (gap_max)
          next_state = sync_s ? LBD_RUN : LBD_SHUT;
      LBD_SHUT:
        if (!vin_ok_i)
          next_state = LBD_OFF;
        else if ((sd_cnt >= REL) && freq_set_pin_s)
          next_state = LBD_RUN;
      LBD_LOWP:
        if (en_s)
          next_state = LBD_OFF;
    endcase
  end

  // state and its timers
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      state   <= LBD_OFF;
      sd_cnt  <= 11'h0_000;
      det_cnt <= 12'h0_000;
    end
    else
    begin
      state   <= next_state;
      sd_cnt  <= (state != LBD_SHUT) ? 11'h0_000 :
                 (sd_cnt < REL) ? sd_cnt + 11'd1 : sd_cnt;
      det_cnt <= !st_det ? 12'h0_000 :
                 (cur_rise && !det_end) ? det_cnt + 12'd1 : det_cnt;
    end
  end

  // internal oscillator and sync watch
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      osc_cnt <= 9'h0_000;
      sync_d  <= 1'b0;
      cur_d   <= 1'b0;
      gap_cnt <= 11'h0_7FF;
      present <= 1'b0;
      use_ext <= 1'b0;
    end
    else
    begin
      osc_cnt <= osc_wrap ? 9'h0_000 : osc_cnt + 9'd1;
      sync_d  <= sync_s;
      cur_d   <= cur_lvl;
      gap_cnt <= sync_rise ? 11'h0_000 :
                 gap_max ? gap_cnt : gap_cnt + 11'd1;
      if (sync_rise)
        present <= ~gap_lost;
      else if (gap_lost)
        present <= 1'b0;
      // a clock stuck high never lets both sources sit low
      if (st_gap && gap_max)
        use_ext <= 1'b0;
      else if (swap_ok)
        use_ext <= present;
    end
  end

  // enable level counters
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      lo_cnt <= 24'h00_0000;
      hi_cnt <= 16'h0_000;
    end
    else
    begin
      lo_cnt <= en_s ? 24'h00_0000 :
                (lo_cnt < LP_N) ? lo_cnt + 24'd1 : lo_cnt;
      hi_cnt <= !en_s ? 16'h0_000 :
                (hi_cnt < FH_N) ? hi_cnt + 16'd1 : hi_cnt;
    end
  end

  // trim duty over a fixed window, then a slow slew
  wire          win_end = &win_cnt;
  wire [8:0]    duty8   = {1'b0, duty_cnt[WB-1:WB-8]} + {8'h00, trim_s};
  wire [7:0]    duty_sat = duty8[8] ? 8'hFF : duty8[7:0];
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      win_cnt      <= '0;
      duty_cnt     <= '0;
      target       <= `LBD_TRIM_RESET;
      slew_cnt     <= '0;
      trim_level_o <= `LBD_TRIM_RESET;
    end
    else
    begin
      win_cnt  <= win_cnt + 1'b1;
      duty_cnt <= win_end ? '0 : duty_cnt + WB'(trim_s);
      if (win_end)
        target <= ~duty_sat;
      slew_cnt <= slew_cnt + 1'b1;
      if (&slew_cnt && trim_level_o < target)
        trim_level_o <= trim_level_o + 8'd1;
      else if (&slew_cnt && trim_level_o > target)
        trim_level_o <= trim_level_o - 8'd1;
    end
  end

  // converter outputs: a few cycles after the enable pin
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      sw_clk_o     <= 1'b0;
      boost_en_o   <= 1'b0;
      sink_en_o    <= 1'b0;
      comp_float_o <= 1'b1;
      disc_sw_on_o <= 1'b0;
      ext_sync_o   <= 1'b0;
      shutdown_o   <= 1'b0;
      low_power_o  <= 1'b0;
      state_o      <= LBD_OFF;
    end
    else
    begin
      sw_clk_o     <= st_run & en_s & cur_lvl;
      boost_en_o   <= st_run & en_s;
      sink_en_o    <= st_run & en_s;
      comp_float_o <= ~(st_run & en_s);
      disc_sw_on_o <= st_det | st_run | st_gap;
      ext_sync_o   <= use_ext;
      shutdown_o   <= (state == LBD_SHUT);
      low_power_o  <= (state == LBD_LOWP);
      state_o      <= state;
    end
  end
endmodule
`default_nettype wire

//--- lbd_defs.svh
// shared constants of the backlight sync and dimming control link
// Notes on behaviour
// - internal clock from resistor, 580 kHz to 2.3 MHz; the clamp here lets it reach 3.5 MHz
// - internal switching never above 3.5 MHz
// - frequency pin shorted low forces shutdown
// - no power-up until frequency pin high or sync
// - changeover to sync clock without glitches
// - host keeps sync high and low 150 ns
// - host keeps sync duty inside allowed range
// - sync lost: pause up to 7 us, resume internal
// - sync low over 7 us: full shutdown
// - enable low 65 ms enters low power
// - after shutdown, release past 5 us restarts
// - enable high: converter on, sinks full current
// - enable low: converter, sinks off, compensation floats
// - current follows enable edges within 500 ns
// - host dims at 200 Hz to 1 kHz
// - trim duty high means less current
// - host trims at 20 kHz to 1 MHz
// - analog dimming trim best 50 to 500 kHz
// - unused trim input tied low
// - trim changes settle over milliseconds
// - host programs current 5% above need
// - start needs first enable pulse and supply
// - detection waits 3000 to 4000 switching cycles
`ifndef LBD_DEFS_SVH
`define LBD_DEFS_SVH

`define LBD_CLK_KHZ        250000
`define LBD_OSC_MAX_KHZ    3500
`define LBD_OSC_LOW_KHZ    580
`define LBD_PER_MIN        ((`LBD_CLK_KHZ + `LBD_OSC_MAX_KHZ - 1) / `LBD_OSC_MAX_KHZ)
`define LBD_PER_MAX        (`LBD_CLK_KHZ / `LBD_OSC_LOW_KHZ)
`define LBD_SYNC_MIN_NS    150
`define LBD_SYNC_MIN_CYC   ((`LBD_SYNC_MIN_NS * 250 + 999) / 1000)
`define LBD_LOSS_NS        2000
`define LBD_LOSS_CYC       (`LBD_LOSS_NS * 250 / 1000)
`define LBD_GAP_NS         7000
`define LBD_GAP_CYC        (`LBD_GAP_NS * 250 / 1000)
`define LBD_REL_NS         5000
`define LBD_REL_CYC        ((`LBD_REL_NS * 250 + 999) / 1000)
`define LBD_LOWPWR_MS      65
`define LBD_LOWPWR_CYC     (`LBD_LOWPWR_MS * 250000)
`define LBD_FIRST_HIGH_CYC 250
`define LBD_DETECT_TICKS   3500
`define LBD_TRIM_WIN_BITS  16
`define LBD_SLEW_BITS      12
`define LBD_TRIM_RESET     8'h00_FF

`define LBD_REG_CTRL       8'h00_00
`define LBD_REG_DIM_PER    8'h00_04
`define LBD_REG_DIM_HIGH   8'h00_08
`define LBD_REG_SYNC_HALF  8'h00_0C
`define LBD_REG_TRIM_PER   8'h00_10
`define LBD_REG_TRIM_HIGH  8'h00_14
`define LBD_REG_STATUS     8'h00_18
`define LBD_CTRL_ENABLE    0
`define LBD_CTRL_DIM       1
`define LBD_CTRL_SYNC      2
`define LBD_CTRL_FREQ_SET_PIN_LOW  3
`define LBD_CTRL_TRIM      4

`endif

//--- lbd_pkg.sv
// types of the backlight sync and dimming control
package lbd_pkg;
  typedef enum logic [5:0] {
    LBD_OFF   = 6'b00_0001,
    LBD_DET   = 6'b00_0010,
    LBD_RUN   = 6'b00_0100,
    LBD_GAP   = 6'b00_1000,
    LBD_SHUT  = 6'b01_0000,
    LBD_LOWP  = 6'b10_0000
  } lbd_state_t;
endpackage

//--- lbd_link_if.sv
// link between system controller and backlight driver control
`timescale 1ns/100ps
`default_nettype none
interface lbd_link_if;
  logic en_dim;
  logic sync_clk;
  logic freq_set_pin_out;
  logic freq_set_pin_oe;
  logic freq_set_pin;
  logic current_trim_pwm_input;

  // pin floats up to its high level once nobody pulls it
  assign freq_set_pin = freq_set_pin_oe ? freq_set_pin_out : 1'b1;

  modport host (output en_dim, sync_clk, freq_set_pin_out,
                freq_set_pin_oe, current_trim_pwm_input,
                input freq_set_pin);
  modport dev (input en_dim, sync_clk, freq_set_pin,
               current_trim_pwm_input);
endinterface
`default_nettype wire

//--- lbd_sync2.sv
// two-stage synchroniser, one stage pair per bit
`timescale 1ns/100ps
`default_nettype none
module lbd_sync2
#(
  parameter int W = 4
)
(
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  genvar i;
  // first stage feeds only the second
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta;
      always_ff @(posedge clk_sys_i)
      begin
        if (!rst_n_i)
        begin
          meta   <= 1'b0;
          q_o[i] <= 1'b0;
        end
        else
        begin
          meta   <= d_i[i];
          q_o[i] <= meta;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- lbd_host.sv
// controller side: AXI4-Lite registers driving enable, sync and trim
`timescale 1ns/100ps
`default_nettype none
`include "lbd_defs.svh"
module lbd_host
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // link to the driver
  lbd_link_if.host         link
);
  import lbd_pkg::*;

  localparam logic [15:0] SYNC_MIN = 16'(`LBD_SYNC_MIN_CYC);

  logic [4:0]  ctrl;
  logic [23:0] per   [2];
  logic [23:0] high  [2];
  logic [23:0] cnt   [2];
  logic [1:0]  pwm;
  logic [15:0] sync_half;
  logic [15:0] sync_cnt;
  logic        freq_set_pin_s;

  // pin coming back from the driver
  lbd_sync2 #(.W(1)) u_sync
  (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .d_i       (link.freq_set_pin),
    .q_o       (freq_set_pin_s)
  );

  // write decode, byte lanes merged into the old value
  wire        wr_go   = s_axi_awvalid_i & s_axi_wvalid_i
                      & ~s_axi_awready_o & ~s_axi_bvalid_o;
  wire [31:0] wmask   = {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
                         {8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};
  wire [7:0]  wa      = s_axi_awaddr_i;
  wire        wa_ok   = (wa <= `LBD_REG_TRIM_HIGH) && (wa[1:0] == 2'b00);
  wire [7:0]  ra      = s_axi_araddr_i;
  wire        rd_go   = s_axi_arvalid_i & ~s_axi_arready_o
                      & ~s_axi_rvalid_o;
  wire        ra_ok   = (ra <= `LBD_REG_STATUS) && (ra[1:0] == 2'b00);
  wire [15:0] half_lim = (sync_half < SYNC_MIN) ? SYNC_MIN : sync_half;

  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~wmask) | (s_axi_wdata_i & wmask);
  endfunction

  // read mux
  wire [31:0] rd_val =
    (ra == `LBD_REG_CTRL)      ? {27'h000_0000, ctrl} :
    (ra == `LBD_REG_DIM_PER)   ? {8'h00, per[0]} :
    (ra == `LBD_REG_DIM_HIGH)  ? {8'h00, high[0]} :
    (ra == `LBD_REG_SYNC_HALF) ? {16'h0000, sync_half} :
    (ra == `LBD_REG_TRIM_PER)  ? {8'h00, per[1]} :
    (ra == `LBD_REG_TRIM_HIGH) ? {8'h00, high[1]} :
    (ra == `LBD_REG_STATUS)    ? {28'h000_0000, link.current_trim_pwm_input,
                                  freq_set_pin_s, link.sync_clk, link.en_dim} :
                                 32'h0000_0000;

  // bus handshakes; unmapped or misaligned words answer SLVERR
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= 2'b00;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rresp_o   <= 2'b00;
      s_axi_rdata_o   <= 32'h0000_0000;
    end
    else
    begin
      s_axi_awready_o <= wr_go;
      s_axi_wready_o  <= wr_go;
      if (wr_go)
      begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wa_ok ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
      s_axi_arready_o <= rd_go;
      if (rd_go)
      begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o  <= ra_ok ? 2'b00 : 2'b10;
        s_axi_rdata_o  <= rd_val;
      end
      else if (s_axi_rready_i)
        s_axi_rvalid_o <= 1'b0;
    end
  end

  // register writes
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      ctrl      <= 5'h0_0;
      per[0]    <= 24'h00_0000;
      high[0]   <= 24'h00_0000;
      per[1]    <= 24'h00_0000;
      high[1]   <= 24'h00_0000;
      sync_half <= 16'h0_000;
    end
    else if (wr_go)
    begin
      if (wa == `LBD_REG_CTRL)
        ctrl <= 5'(merge({27'h000_0000, ctrl}));
      if (wa == `LBD_REG_DIM_PER)
        per[0] <= 24'(merge({8'h00, per[0]}));
      if (wa == `LBD_REG_DIM_HIGH)
        high[0] <= 24'(merge({8'h00, high[0]}));
      if (wa == `LBD_REG_SYNC_HALF)
        sync_half <= 16'(merge({16'h0000, sync_half}));
      if (wa == `LBD_REG_TRIM_PER)
        per[1] <= 24'(merge({8'h00, per[1]}));
      if (wa == `LBD_REG_TRIM_HIGH)
        high[1] <= 24'(merge({8'h00, high[1]}));
    end
  end

  // dimming and trim waveforms, one counter each
  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_pwm
      always_ff @(posedge clk_sys_i)
      begin
        if (!rst_n_i)
        begin
          cnt[i] <= 24'h00_0000;
          pwm[i] <= 1'b0;
        end
        else
        begin
          cnt[i] <= (cnt[i] >= per[i]) ? 24'h00_0000 : cnt[i] + 24'd1;
          pwm[i] <= (cnt[i] < high[i]);
        end
      end
    end
  endgenerate

  // link outputs; sync halves never shorter than the minimum
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      sync_cnt                    <= 16'h0_000;
      link.sync_clk               <= 1'b0;
      link.en_dim                 <= 1'b0;
      link.freq_set_pin_out       <= 1'b0;
      link.freq_set_pin_oe        <= 1'b0;
      link.current_trim_pwm_input <= 1'b0;
    end
    else
    begin
      if (!ctrl[`LBD_CTRL_SYNC])
      begin
        sync_cnt      <= 16'h0_000;
        link.sync_clk <= 1'b0;
      end
      else if (sync_cnt >= half_lim - 16'd1)
      begin
        sync_cnt      <= 16'h0_000;
        link.sync_clk <= ~link.sync_clk;
      end
      else
        sync_cnt <= sync_cnt + 16'd1;
      link.en_dim <= ctrl[`LBD_CTRL_ENABLE]
                   & (~ctrl[`LBD_CTRL_DIM] | pwm[0]);
      link.freq_set_pin_out <= 1'b0;
      link.freq_set_pin_oe  <= ctrl[`LBD_CTRL_FREQ_SET_PIN_LOW];
      link.current_trim_pwm_input <= ctrl[`LBD_CTRL_TRIM]
                                   & pwm[1];
    end
  end
endmodule
`default_nettype wire

//--- lbd_link_sva.sv
// assertion checker for the backlight sync and dimming link
`timescale 1ns/100ps
`default_nettype none
module lbd_link_sva
(
  // clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rst_n_i,
  // link pins
  input  wire logic                en_dim,
  input  wire logic                freq_set_pin,
  // driver outputs
  input  wire logic                sw_clk_o,
  input  wire logic                boost_en_o,
  input  wire logic                sink_en_o,
  input  wire logic                comp_float_o,
  input  wire logic                disc_sw_on_o,
  input  wire logic                ext_sync_o,
  input  wire logic                shutdown_o,
  input  wire logic                low_power_o,
  input  wire lbd_pkg::lbd_state_t state_o
);
  import lbd_pkg::*;

  // one clock domain, so one default clock and reset
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_sink_boost_pair : assert property
    (sink_en_o == boost_en_o)
    else $error("sink and boost enables disagree");
  chk_comp_float_inv : assert property
    (comp_float_o != boost_en_o)
    else $error("compensation float not inverse of boost enable");
  // sync delay is 3 to 4 cycles, so 6 samples leave a margin
  chk_enable_low_off : assert property
    (!en_dim [*6] |-> !boost_en_o && !sink_en_o)
    else $error("converter still on after enable low");
  chk_enable_high_on : assert property
    ((en_dim && state_o == LBD_RUN) [*6] |-> boost_en_o && sink_en_o)
    else $error("converter off while running with enable high");
  chk_switch_run_only : assert property
    ((state_o != LBD_RUN) [*2] |-> !sw_clk_o)
    else $error("switching outside run state");
  chk_shut_outputs : assert property
    ((state_o == LBD_SHUT) [*2] |-> shutdown_o && !disc_sw_on_o && !sink_en_o)
    else $error("shutdown leaves disconnect or sinks on");
  // loss seen at 500 cycles, decision at 1750, so about 1250 in the pause
  logic [10:0] gap_len;
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      gap_len <= 11'h000;
    else
      gap_len <= (state_o == LBD_GAP) ? gap_len + 11'd1 : 11'h000;
  end
  chk_gap_bounded : assert property
    (gap_len <= 11'd1300)
    else $error("switching pause too long");
  chk_freq_set_pin_short : assert property
    ((!freq_set_pin && !ext_sync_o && state_o != LBD_GAP) [*8]
      |-> !(state_o inside {LBD_DET, LBD_RUN}))
    else $error("running with frequency pin low and no sync");

  // main scenarios reached
  cov_sync_run : cover property (state_o == LBD_RUN && ext_sync_o);
  cov_gap : cover property (state_o == LBD_GAP);
  cov_shut : cover property (state_o == LBD_SHUT);
  cov_low_power : cover property (low_power_o);
endmodule
`default_nettype wire

//--- test_led_boost_sync_dim_control.sv
// testbench of host and driver control joined over the link
`timescale 1ns/100ps
`default_nettype none
module test_led_boost_sync_dim_control;
  import lbd_pkg::*;

  logic        clk_sys_i, rst_n_i, vin_ok;
  logic [7:0]  awaddr, araddr, trim;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        sw_clk, boost_en, sink_en, comp_float, disc_on;
  logic        ext_sync, shut, low_pwr;
  lbd_state_t  st;
  int          err_count, compares, n, hi;

  lbd_link_if link_i ();
  lbd_host lbd_host_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .link(link_i));
  // short low-power and detection counts keep the run brief
  lbd_device #(.LOWPWR_CYC(2000), .FIRST_HIGH_CYC(250),
    .DETECT_TICKS(400)) lbd_device_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(link_i),
    // period below the fastest allowed one must be clamped
    .vin_ok_i(vin_ok), .osc_period_i(9'h020), .sw_clk_o(sw_clk),
    .boost_en_o(boost_en), .sink_en_o(sink_en), .comp_float_o(comp_float),
    .disc_sw_on_o(disc_on), .trim_level_o(trim), .ext_sync_o(ext_sync),
    .shutdown_o(shut), .low_power_o(low_pwr), .state_o(st));
  lbd_link_sva lbd_link_sva_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .en_dim(link_i.en_dim), .freq_set_pin(link_i.freq_set_pin),
    .sw_clk_o(sw_clk), .boost_en_o(boost_en), .sink_en_o(sink_en),
    .comp_float_o(comp_float), .disc_sw_on_o(disc_on),
    .ext_sync_o(ext_sync), .shutdown_o(shut), .low_power_o(low_pwr),
    .state_o(st));

  // 250 MHz system clock
  initial
  begin
    clk_sys_i = 1'h0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // each channel released at its own ready, response awaited with bready up
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk_sys_i);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    resp = bresp;
    bready <= 1'h0;
    @(posedge clk_sys_i);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk_sys_i);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rd = rdata;
    resp = rresp;
    rready <= 1'h0;
    @(posedge clk_sys_i);
  endtask

  // bounded waits; a miss shows up in the next compare
  task automatic wst(input lbd_state_t s, input bit eq, input int lim);
    n = 0;
    while (((st === s) != eq) && n < lim)
    begin
      @(posedge clk_sys_i);
      n++;
    end
  endtask

  task automatic wbit(ref logic s, input int lim);
    n = 0;
    while (s !== 1'h1 && n < lim)
    begin
      @(posedge clk_sys_i);
      n++;
    end
  endtask

  // run is about 70k cycles, mostly the first trim window
  initial
  begin
    #400_000;
    err_count++;
    tally_and_finish;
  end

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0000_0000, 4'hF};
    rst_n_i = 1'h0;
    vin_ok = 1'h1;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    @(posedge clk_sys_i);
    chk("comp_float", comp_float, 1'h1);
    chk("trim", trim, 8'hFF);
    // returned pin level needs its synchroniser first
    repeat (2) @(posedge clk_sys_i);
    axi_rd(8'h18);
    chk("status", rd, 32'h0000_0004);
    chk("rresp", resp, 2'h0);
    axi_rd(8'h1C);
    chk("rresp", resp, 2'h2);
    axi_wr(8'h18, 32'h0000_0001);
    chk("bresp", resp, 2'h2);
    axi_wr(8'h00, 32'h0000_0009);
    chk("bresp", resp, 2'h0);
    axi_rd(8'h00);
    chk("ctrl", rd, 32'h0000_0009);
    repeat (600) @(posedge clk_sys_i);
    chk("disc_on", disc_on, 1'h0);
    // 250 kHz trim at 25 percent duty
    axi_wr(8'h10, 32'h0000_03E7);
    axi_wr(8'h14, 32'h0000_00FA);
    axi_wr(8'h00, 32'h0000_0011);
    repeat (300) @(posedge clk_sys_i);
    chk("trim_slow", trim, 8'hFF);
    wst(LBD_RUN, 1, 40000);
    chk("state", st, LBD_RUN);
    chk("detect_len", n > 21600, 1'h1);
    chk("boost", boost_en, 1'h1);
    chk("comp_float", comp_float, 1'h0);
    axi_wr(8'h0C, 32'h0000_0064);
    axi_wr(8'h00, 32'h0000_0015);
    wbit(ext_sync, 2000);
    chk("ext_sync", ext_sync, 1'h1);
    chk("boost", boost_en, 1'h1);
    // a very long half period leaves the sync clock stuck high
    @(posedge link_i.sync_clk);
    @(posedge clk_sys_i);
    axi_wr(8'h0C, 32'h0000_FFFF);
    wst(LBD_GAP, 1, 1000);
    wst(LBD_GAP, 0, 1400);
    chk("state", st, LBD_RUN);
    chk("ext_sync", ext_sync, 1'h0);
    axi_wr(8'h0C, 32'h0000_0064);
    wbit(ext_sync, 2000);
    @(negedge link_i.sync_clk);
    @(posedge clk_sys_i);
    axi_wr(8'h00, 32'h0000_0011);
    wst(LBD_GAP, 1, 1000);
    wst(LBD_GAP, 0, 1400);
    chk("state", st, LBD_SHUT);
    wst(LBD_SHUT, 0, 2000);
    chk("state", st, LBD_RUN);
    chk("shut_len", n > 1200, 1'h1);
    axi_wr(8'h00, 32'h0000_0019);
    repeat (20) @(posedge clk_sys_i);
    chk("state", st, LBD_SHUT);
    axi_wr(8'h00, 32'h0000_0011);
    wst(LBD_SHUT, 0, 2000);
    chk("state", st, LBD_RUN);
    axi_wr(8'h04, 32'h0000_0063);
    axi_wr(8'h08, 32'h0000_0032);
    axi_wr(8'h00, 32'h0000_0013);
    hi = 0;
    repeat (1000)
    begin
      @(posedge clk_sys_i);
      hi += (boost_en === 1'h1);
    end
    chk("dim_duty", hi > 400 && hi < 600, 1'h1);
    axi_wr(8'h00, 32'h0000_0010);
    wbit(low_pwr, 2500);
    chk("low_power", low_pwr, 1'h1);
    chk("low_len", n > 1900, 1'h1);
    // supply below lockout keeps it off past the first pulse time
    vin_ok <= 1'h0;
    axi_wr(8'h00, 32'h0000_0011);
    repeat (300) @(posedge clk_sys_i);
    chk("state", st, LBD_OFF);
    vin_ok <= 1'h1;
    // trim moves only after its first full window
    n = 0;
    while (trim === 8'hFF && n < 40000)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    chk("trim_down", trim < 8'hFF, 1'h1);
    tally_and_finish;
  end
endmodule
`default_nettype wire
